// ### external_bus_memory_map.sv
// Memory-map decoder and primary external bus controller
`timescale 1ns/100ps
// Functional notes
// - Single 16M-word space of 32-bit words
// - 808000h-8097ffh goes to peripheral registers
// - First RAM at 809800h-809bffh both modes
// - Second RAM follows at 809c00h
// - Boot-select low microprocessor, high bootloader
// - Microprocessor mode: vectors fetched externally with strobe
// - Microprocessor mode: other ranges go external
// - Bootloader mode: ROM 0-0fffh, rest external
// - On-chip blocks take two accesses per cycle
// - 24-bit address, 32-bit two-way data, controls
// - External access held until ready seen
// - Strobe stays low across same-bank reads
// - Bank crossing inserts idle gap when enabled
// - Release request floats bus after current cycle
// - Acknowledge asserted once bus is floated
// - Acknowledge drops on request high or ignore
// - Read-not-write high for reads, low writes
module external_bus_memory_map
  import ext_bus_pkg::*;
#(
  parameter int BANK_GAP = 2                // Idle cycles on bank crossing
)(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                reset_n,
  // Straps and controls
  input  wire logic                boot_map_select,
  input  wire logic                ignore_release_request,
  input  wire logic                bank_switch_enable,
  // Two processor request ports, one result each
  input  wire bus_req_s            req_a,
  input  wire bus_req_s            req_b,
  output logic                     ready_a,
  output logic                     ready_b,
  output logic [DATA_W-1:0]        rdata_a,
  output logic [DATA_W-1:0]        rdata_b,
  output region_e                  region_a,
  output region_e                  region_b,
  // External primary bus
  output ext_pins_s                ext_out,
  input  wire logic [DATA_W-1:0]   ext_data_in,
  input  wire logic                ext_ready_n,
  // Bus release handshake
  input  wire logic                release_request_n,
  output logic                     bus_release_ack_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: first stage feeds only the second stage
  logic [DATA_W-1:0] din_s1_reg, din_reg;   // External read data
  logic rdy_s1_reg, rdy_reg;                // Ready, active low
  logic hold_s1_reg, hold_reg;              // Release request, active low
  logic mode_s1_reg, mode_reg;              // Boot-select strap

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdy_s1_reg  <= 1'b1;
      rdy_reg     <= 1'b1;
      hold_s1_reg <= 1'b1;
      hold_reg    <= 1'b1;
      mode_s1_reg <= 1'b0;
      mode_reg    <= 1'b0;
      din_s1_reg  <= DATA_RST;
      din_reg     <= DATA_RST;
    end else begin
      rdy_s1_reg  <= ext_ready_n;
      rdy_reg     <= rdy_s1_reg;
      hold_s1_reg <= release_request_n;
      hold_reg    <= hold_s1_reg;
      mode_s1_reg <= boot_map_select;
      mode_reg    <= mode_s1_reg;
      din_s1_reg  <= ext_data_in;
      din_reg     <= din_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decoder, one copy per request port
  function automatic region_e decode(input logic [23:0] a, input logic boot);
    region_e r;
    r = REG_EXTERNAL;
    if (a >= PERIPH_LO && a <= PERIPH_HI) begin
      r = REG_PERIPH;
    end else if (a >= RAM0_LO && a <= RAM0_HI) begin
      r = REG_RAM0;
    end else if (a >= RAM1_LO && a <= RAM1_HI) begin
      r = REG_RAM1;
    end else if (boot && a <= BOOTROM_HI) begin
      r = REG_BOOTROM;
    end
    return r;
  endfunction

  region_e reg_a_dec, reg_b_dec;
  assign reg_a_dec = decode(req_a.addr, mode_reg);
  assign reg_b_dec = decode(req_b.addr, mode_reg);

  ////////////////////////////////////////////////////////////////////////////
  // On-chip RAM blocks and ROM: both ports served each cycle
  localparam int RAM_WORDS = 1024;
  localparam int ROM_WORDS = 4096;
  logic [DATA_W-1:0] ram0_mem [RAM_WORDS];              // First RAM block
  logic [DATA_W-1:0] ram1_mem [RAM_WORDS];              // Second RAM block
  logic [DATA_W-1:0] rom_mem  [ROM_WORDS];              // Boot ROM image

  // Boot program content is supplied elsewhere; zero image here
  always_comb begin
    for (int i = 0; i < ROM_WORDS; i++) begin
      rom_mem[i] = DATA_RST;
    end
  end

  // Writes: port b wins on a same-word collision, as later in program order
  always_ff @(posedge core_clk) begin
    if (req_a.valid && req_a.write && reg_a_dec == REG_RAM0)
      ram0_mem[req_a.addr[9:0]] <= req_a.wdata;
    if (req_b.valid && req_b.write && reg_b_dec == REG_RAM0)
      ram0_mem[req_b.addr[9:0]] <= req_b.wdata;
    if (req_a.valid && req_a.write && reg_a_dec == REG_RAM1)
      ram1_mem[req_a.addr[9:0]] <= req_a.wdata;
    if (req_b.valid && req_b.write && reg_b_dec == REG_RAM1)
      ram1_mem[req_b.addr[9:0]] <= req_b.wdata;
  end

  function automatic logic [DATA_W-1:0] local_read(input region_e r,
                                                   input logic [23:0] a);
    logic [DATA_W-1:0] d;
    d = DATA_RST;                       // Peripheral space reads zero here
    case (r)
      REG_RAM0:    d = ram0_mem[a[9:0]];
      REG_RAM1:    d = ram1_mem[a[9:0]];
      REG_BOOTROM: d = rom_mem[a[11:0]];
      default:     d = DATA_RST;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // External bus state machine (port a owns the external port)
  typedef enum logic [2:0] {
    S_IDLE, S_GAP, S_ACCESS, S_HOLD
  } bus_state_e;
  bus_state_e state_reg;
  logic [3:0]  gap_cnt_reg;                 // Bank gap and sync dwell count
  logic [7:0]  last_bank_reg;               // Bank of previous access
  logic        ext_req;

  assign ext_req = req_a.valid && reg_a_dec == REG_EXTERNAL;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg         <= S_IDLE;
      gap_cnt_reg       <= 4'h0;
      last_bank_reg     <= 8'h00;
      ext_out           <= '0;
      ext_out.external_access_strobe_n <= 1'b1;
      ext_out.read_not_write           <= 1'b1;
      bus_release_ack_n <= 1'b1;
    end else begin
      case (state_reg)
        S_IDLE: begin
          ext_out.ctrl_oe <= 1'b1;
          // Release only between cycles so the current one finishes
          if (!hold_reg && !ignore_release_request) begin
            ext_out.ctrl_oe <= 1'b0;
            ext_out.data_oe <= 1'b0;
            ext_out.external_access_strobe_n <= 1'b1;
            state_reg <= S_HOLD;
          end else if (ext_req) begin
            if (bank_switch_enable &&
                req_a.addr[23:BANK_LSB] != last_bank_reg) begin
              ext_out.external_access_strobe_n <= 1'b1;
              gap_cnt_reg <= 4'(BANK_GAP);
              state_reg   <= S_GAP;
            end else begin
              ext_out.addr           <= req_a.addr;
              ext_out.data_out       <= req_a.wdata;
              ext_out.data_oe        <= req_a.write;
              ext_out.read_not_write <= !req_a.write;
              ext_out.external_access_strobe_n <= 1'b0;
              last_bank_reg <= req_a.addr[23:BANK_LSB];
              gap_cnt_reg   <= SYNC_DWELL;
              state_reg     <= S_ACCESS;
            end
          end else begin
            // No external work now, so on-chip cycles see it high
            ext_out.external_access_strobe_n <= 1'b1;
          end
        end
        S_GAP: begin
          if (gap_cnt_reg <= 4'h1) begin
            state_reg <= S_IDLE;
            last_bank_reg <= req_a.addr[23:BANK_LSB];
          end
          gap_cnt_reg <= gap_cnt_reg - 4'h1;
        end
        S_ACCESS: begin
          if (gap_cnt_reg != 4'h0) begin
            // Syncs still carry ready and data from before this access
            gap_cnt_reg <= gap_cnt_reg - 4'h1;
          end else if (!rdy_reg) begin
            // Reads keep the strobe low for a same-bank follow-on
            if (!ext_out.read_not_write ||
                !(ext_req && !req_a.write &&
                  req_a.addr[23:BANK_LSB] == last_bank_reg)) begin
              ext_out.external_access_strobe_n <= 1'b1;
            end
            ext_out.data_oe <= 1'b0;
            state_reg <= S_IDLE;
          end
        end
        S_HOLD: begin
          bus_release_ack_n <= 1'b0;
          if (hold_reg || ignore_release_request) begin
            bus_release_ack_n <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request completion and read data to the processor ports
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ready_a  <= 1'b0;
      ready_b  <= 1'b0;
      rdata_a  <= DATA_RST;
      rdata_b  <= DATA_RST;
      region_a <= REG_PERIPH;
      region_b <= REG_PERIPH;
    end else begin
      region_a <= reg_a_dec;
      region_b <= reg_b_dec;
      // On-chip answers in one cycle on each port
      ready_b  <= req_b.valid && reg_b_dec != REG_EXTERNAL;
      rdata_b  <= local_read(reg_b_dec, req_b.addr);
      if (ext_req) begin
        ready_a <= state_reg == S_ACCESS && gap_cnt_reg == 4'h0 &&
                   !rdy_reg;
        rdata_a <= din_reg;
      end else begin
        ready_a <= req_a.valid;
        rdata_a <= local_read(reg_a_dec, req_a.addr);
      end
    end
  end

endmodule

// ### ext_bus_pkg.sv
// Package: address map, field widths and bus carrier types for the decoder
package ext_bus_pkg;

  localparam int ADDR_W = 24;                         // Word address width
  localparam int DATA_W = 32;                         // Word width

  // Region bounds (word addresses)
  localparam logic [23:0] PERIPH_LO   = 24'h808000;   // Peripheral regs
  localparam logic [23:0] PERIPH_HI   = 24'h8097ff;
  localparam logic [23:0] RAM0_LO     = 24'h809800;   // First RAM block
  localparam logic [23:0] RAM0_HI     = 24'h809bff;
  localparam logic [23:0] RAM1_LO     = 24'h809c00;   // Second RAM block
  localparam logic [23:0] RAM1_HI     = 24'h809fff;
  localparam logic [23:0] VECTOR_HI   = 24'h0000bf;   // Vector area top
  localparam logic [23:0] BOOTROM_HI  = 24'h000fff;   // Boot ROM top

  // Bank select uses the upper address bits from this position upward
  localparam int          BANK_LSB    = 16;
  localparam logic [3:0]  BANK_GAP_CYCLES = 4'h2;     // Bank-switch idle gap
  // Access cycles before ready counts: pin syncs must show this access
  localparam logic [3:0]  SYNC_DWELL      = 4'h2;

  // Reset values
  localparam logic [23:0] ADDR_RST    = 24'h000000;
  localparam logic [31:0] DATA_RST    = 32'h00000000;

  typedef enum logic [2:0] {
    REG_PERIPH,
    REG_RAM0,
    REG_RAM1,
    REG_BOOTROM,
    REG_EXTERNAL
  } region_e;

  // One processor request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [23:0] addr;
    logic [31:0] wdata;
  } bus_req_s;

  // Pins of the primary external bus as driven by the device
  typedef struct packed {
    logic [23:0] addr;
    logic [31:0] data_out;
    logic        data_oe;
    logic        ctrl_oe;
    logic        read_not_write;
    logic        external_access_strobe_n;
  } ext_pins_s;

endpackage

// ### ext_bus_sva.sv
// Checker for the memory-map decoder and its external bus
`timescale 1ns/100ps
module ext_bus_sva
  import ext_bus_pkg::*;
(
  // Clock, reset and straps
  input wire logic      core_clk,
  input wire logic      reset_n,
  input wire logic      boot_map_select,
  input wire logic      ignore_release_request,
  // Processor port a
  input wire bus_req_s  req_a,
  input wire logic      ready_a,
  input wire region_e   region_a,
  // External bus and release handshake
  input wire ext_pins_s ext_out,
  input wire logic      release_request_n,
  input wire logic      bus_release_ack_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire logic        stb_n = ext_out.external_access_strobe_n; // Strobe
  wire logic [23:0] a     = req_a.addr;                       // Address
  // On-chip RAM request on port a
  wire logic ram = req_a.valid && a >= RAM0_LO && a <= RAM1_HI;
  property p_ram0;
    req_a.valid && a >= RAM0_LO && a <= RAM0_HI |=> region_a == REG_RAM0;
  endproperty
  a_ram0: assert property (p_ram0) else $error("ram0 decode");
  property p_ram1;
    req_a.valid && a >= RAM1_LO && a <= RAM1_HI |=> region_a == REG_RAM1;
  endproperty
  a_ram1: assert property (p_ram1) else $error("ram1 decode");
  property p_periph;
    req_a.valid && a >= PERIPH_LO && a <= PERIPH_HI
      |=> region_a == REG_PERIPH;
  endproperty
  a_periph: assert property (p_periph) else $error("periph decode");
  property p_boot;
    req_a.valid && boot_map_select && a <= BOOTROM_HI
      |=> region_a == REG_BOOTROM;
  endproperty
  a_boot: assert property (p_boot) else $error("boot decode");
  property p_vec;
    req_a.valid && !boot_map_select && a <= VECTOR_HI
      |=> region_a == REG_EXTERNAL;
  endproperty
  a_vec: assert property (p_vec) else $error("vector decode");
  property p_quiet;
    ram |-> stb_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("strobe on ram");
  property p_ready;
    ram |=> ready_a;
  endproperty
  a_ready: assert property (p_ready) else $error("ram stall");
  property p_hold;
    $fell(stb_n) |-> !stb_n [*3];
  endproperty
  a_hold: assert property (p_hold) else $error("short access");
  property p_rnw;
    !stb_n && req_a.valid |-> ext_out.read_not_write == !req_a.write;
  endproperty
  a_rnw: assert property (p_rnw) else $error("rnw level");
  property p_float;
    !bus_release_ack_n |-> !ext_out.ctrl_oe && !ext_out.data_oe;
  endproperty
  a_float: assert property (p_float) else $error("bus driven");
  property p_ack;
    $fell(bus_release_ack_n) |-> !$past(release_request_n) && $past(stb_n);
  endproperty
  a_ack: assert property (p_ack) else $error("ack cause");
  property p_ign;
    ignore_release_request [*5] |-> bus_release_ack_n;
  endproperty
  a_ign: assert property (p_ign) else $error("ack kept");
endmodule
bind external_bus_memory_map ext_bus_sva chk (.core_clk(core_clk),
  .reset_n(reset_n), .boot_map_select(boot_map_select),
  .ignore_release_request(ignore_release_request), .req_a(req_a),
  .ready_a(ready_a), .region_a(region_a), .ext_out(ext_out),
  .release_request_n(release_request_n),
  .bus_release_ack_n(bus_release_ack_n));

// ### ext_mem_model.sv
// External memory model on the primary bus
`timescale 1ns/100ps
module ext_mem_model
  import ext_bus_pkg::*;
(
  // Clock and wait setting
  input  wire logic       core_clk,
  input  wire logic [3:0] wait_cycles,
  // Bus from the device
  input  wire ext_pins_s  ext_out,
  // Answer to the device
  output logic [31:0]     ext_data_in,
  output logic            ext_ready_n
);
  logic [31:0] mem [16];            // Small word store
  logic [3:0]  cnt_reg  = 4'h0;     // Wait states so far
  logic [31:0] last_reg = 32'h0;    // Last word driven
  wire logic   sel = ext_out.ctrl_oe && !ext_out.external_access_strobe_n;
  // Ready only once the wait count has run out
  always_ff @(posedge core_clk) begin
    if (!sel) begin
      cnt_reg     <= 4'h0;
      ext_ready_n <= 1'b1;
    end else begin
      if (cnt_reg != wait_cycles) begin
        cnt_reg <= cnt_reg + 4'h1;
      end
      ext_ready_n <= (cnt_reg != wait_cycles);
      if (!ext_out.read_not_write && ext_out.data_oe) begin
        mem[ext_out.addr[3:0]] <= ext_out.data_out;
      end
    end
    if (sel && ext_out.read_not_write) begin
      last_reg <= mem[ext_out.addr[3:0]];
    end
  end
  // Released data lines show the inverse so no stale word passes
  assign ext_data_in = (sel && ext_out.read_not_write) ?
                       mem[ext_out.addr[3:0]] : ~last_reg;
endmodule

// ### tb.sv
// Self-checking bench for the memory-map decoder
`timescale 1ns/100ps
module tb;
  import ext_bus_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        boot = 1'b0, ign = 1'b0, bank_en = 1'b0, rel_n = 1'b1;
  logic [3:0]  wait_cycles = 4'h0;
  bus_req_s    req_a = '0, req_b = '0;
  logic        ready_a, ready_b, ack_n, ext_ready_n;
  logic [31:0] rdata_a, rdata_b, ext_data_in;
  region_e     region_a, region_b;
  ext_pins_s   ext_out;
  int          failures = 0;
  int          checked  = 0;
  int          cycles   = 0;         // Edges the last access took
  int          gap_n    = 0;         // Edges of the bank-crossing write
  logic [23:0] tab [4];              // Address table per scenario
  always #4 core_clk = ~core_clk;
  external_bus_memory_map uut (.core_clk(core_clk), .reset_n(reset_n),
    .boot_map_select(boot), .ignore_release_request(ign),
    .bank_switch_enable(bank_en), .req_a(req_a), .req_b(req_b),
    .ready_a(ready_a), .ready_b(ready_b), .rdata_a(rdata_a),
    .rdata_b(rdata_b), .region_a(region_a), .region_b(region_b),
    .ext_out(ext_out), .ext_data_in(ext_data_in),
    .ext_ready_n(ext_ready_n), .release_request_n(rel_n),
    .bus_release_ack_n(ack_n));
  ext_mem_model mem (.core_clk(core_clk), .wait_cycles(wait_cycles),
    .ext_out(ext_out), .ext_data_in(ext_data_in),
    .ext_ready_n(ext_ready_n));
  ////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Compare one word or flag
  task automatic chk(input logic [31:0] e, g, input string m);
    checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Compare one region code
  task automatic chk_reg(input region_e e, g);
    chk({29'h0, e}, {29'h0, g}, "region");
  endtask
  // Reset for 6 cycles, then let the strap settle
  task automatic do_reset();
    reset_n = 1'b0;
    repeat (6) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask
  // One access on port a held until ready, bounded
  task automatic acc(input logic w, input logic [23:0] a,
                     input logic [31:0] d, input region_e r);
    int n;
    req_a = '{1'b1, w, a, d};
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (ready_a !== 1'b1 && n < 60);
    cycles = n;
    chk(1'b1, ready_a, "no ready");
    if (n >= 60) stop_test();
    if (!w) chk(d, rdata_a, "read data");
    chk_reg(r, region_a);
    @(negedge core_clk);
    req_a.valid = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  // Wait for the acknowledge level, bounded
  task automatic wait_ack(input logic v);
    int n;
    for (n = 0; n < 30 && ack_n !== v; n++) @(negedge core_clk);
    chk(v, ack_n, "ack level");
    if (n >= 30) stop_test();
  endtask
  ////////////////////////////////////////////////////////////////////
  // Both RAM blocks at their edges, written then read back
  task automatic t_onchip();
    tab = '{RAM0_LO, RAM0_HI, RAM1_LO, RAM1_HI};
    foreach (tab[i]) acc(1'b1, tab[i], {8'h5a, tab[i]},
                         i < 2 ? REG_RAM0 : REG_RAM1);
    foreach (tab[i]) acc(1'b0, tab[i], {8'h5a, tab[i]},
                         i < 2 ? REG_RAM0 : REG_RAM1);
    // Two ports in one cycle, neither stalls
    req_a = '{1'b1, 1'b0, RAM0_LO, 32'h0};
    req_b = '{1'b1, 1'b0, RAM1_HI, 32'h0};
    @(posedge core_clk);
    @(posedge core_clk);
    #1;
    chk({1'b1, 1'b1}, {ready_a, ready_b}, "dual ready");
    chk({8'h5a, RAM1_HI}, rdata_b, "port b data");
    chk({8'h5a, RAM0_LO}, rdata_a, "port a data");
    chk_reg(REG_RAM1, region_b);
    @(negedge core_clk);
    req_a.valid = 1'b0;
    req_b.valid = 1'b0;
    repeat (2) @(negedge core_clk);
    acc(1'b1, PERIPH_LO, 32'hdead0001, REG_PERIPH);
    acc(1'b0, PERIPH_HI, 32'h0, REG_PERIPH);
    $display("test onchip done");
  endtask
  // Microprocessor map: vectors and both outer ranges go out
  task automatic t_ext();
    tab = '{VECTOR_HI, 24'h0000c0, 24'h07ffff, 24'h80a000};
    foreach (tab[i]) begin
      wait_cycles = 4'(i * 3);
      bank_en = (i == 3);
      acc(1'b1, tab[i], {8'ha5, tab[i]}, REG_EXTERNAL);
      gap_n = cycles;
      chk(tab[i], ext_out.addr, "bus address");
      acc(1'b0, tab[i], {8'ha5, tab[i]}, REG_EXTERNAL);
      // Crossing adds the idle gap plus one edge to re-arbitrate
      if (i == 3)
        chk(BANK_GAP_CYCLES + 1, gap_n - cycles, "bank gap");
    end
    $display("test external done");
  endtask
  // Bootloader map: ROM reads zero, the word above goes out
  task automatic t_boot();
    boot = 1'b1;
    do_reset();
    acc(1'b0, BOOTROM_HI, 32'h0, REG_BOOTROM);
    acc(1'b1, 24'h001000, 32'h0b0b0b0b, REG_EXTERNAL);
    acc(1'b0, 24'h001000, 32'h0b0b0b0b, REG_EXTERNAL);
    boot = 1'b0;
    do_reset();
    $display("test boot done");
  endtask
  // Release handshake; the bench as other master drives nothing
  task automatic t_release();
    rel_n = 1'b0;
    wait_ack(1'b0);
    chk(1'b0, ext_out.ctrl_oe, "bus not floated");
    chk(1'b0, ext_out.data_oe, "data not floated");
    ign = 1'b1;
    wait_ack(1'b1);
    ign = 1'b0;
    wait_ack(1'b0);
    rel_n = 1'b1;
    wait_ack(1'b1);
    $display("test release done");
  endtask
  initial begin
    do_reset();
    t_onchip();
    t_ext();
    t_boot();
    t_release();
    stop_test();
  end
endmodule
